// File: ccs_clk_route.sv
// Routing of clock enable pulses to the watchdog, timer H1 and peripherals
// Assumes every tick input is a one-cycle pulse on clk
`timescale 1ns/10ps

module ccs_clk_route (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Source ticks
  input  wire logic        low_tick,
  input  wire logic        periph_tick,
  input  wire logic        ext_tick,
  input  wire logic        tm0_edge,
  // Selects
  input  wire logic        periph_stop,
  input  ccs_pkg::ccs_h1_sel_t h1_sel,
  input  wire logic        ext_sel,
  input  wire logic        tm0_ext_sel,
  // Enables out
  output logic             wdt_en_r,
  output logic             h1_en_r,
  output logic             periph_en_r,
  output logic             ext_en_r,
  output logic             tm0_en_r
);
  import ccs_pkg::*;

  logic [`CCS_LS_DIV_W-1:0] div_r, div_nxt;
  logic wdt_nxt, h1_nxt, per_nxt, ext_nxt, tm0_nxt;
  logic per_run;

  always_comb begin
    div_nxt = low_tick ? div_r + 1'b1 : div_r;
    per_run = periph_tick && !periph_stop;
    per_nxt = per_run;
    // Watchdog never follows the main or peripheral selects
    wdt_nxt = low_tick;
    unique case (h1_sel)
      CCS_H1_PERIPH:   h1_nxt = per_run;
      CCS_H1_LOW:      h1_nxt = low_tick;
      CCS_H1_LOW_D8:   h1_nxt = low_tick && (div_r[2:0] == 3'h7);
      CCS_H1_LOW_D512: h1_nxt = low_tick && (&div_r);
    endcase
    ext_nxt = ext_sel ? ext_tick : per_run;
    // Timer zero edges are sampled on the peripheral clock, so they stop with it
    tm0_nxt = tm0_ext_sel ? (tm0_edge && per_run) : per_run;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      div_r       <= '0;
      wdt_en_r    <= 1'b0;
      h1_en_r     <= 1'b0;
      periph_en_r <= 1'b0;
      ext_en_r    <= 1'b0;
      tm0_en_r    <= 1'b0;
    end else begin
      div_r       <= div_nxt;
      wdt_en_r    <= wdt_nxt;
      h1_en_r     <= h1_nxt;
      periph_en_r <= per_nxt;
      ext_en_r    <= ext_nxt;
      tm0_en_r    <= tm0_nxt;
    end
  end

  wdt_follows_a: assert property (@(posedge clk) disable iff (reset)
    wdt_en_r == $past(low_tick)) else $error("watchdog enable not from low-speed tick");
  h1_low_a: assert property (@(posedge clk) disable iff (reset)
    $past(h1_sel) == CCS_H1_LOW |-> h1_en_r == $past(low_tick)) else $error("timer H1 not on low-speed clock");
  ext_src_a: assert property (@(posedge clk) disable iff (reset)
    $past(ext_sel) |-> ext_en_r == $past(ext_tick)) else $error("external clock not routed");
  stop_quiet_a: assert property (@(posedge clk) disable iff (reset)
    $past(periph_stop) |-> !periph_en_r && !tm0_en_r) else $error("peripheral clock ran while stopped");
  d512_c: cover property (@(posedge clk) disable iff (reset) h1_sel == CCS_H1_LOW_D512 ##1 h1_en_r);
endmodule : ccs_clk_route

// File: ccs_pkg.sv
// Types shared by the clock source and stabilization block
// Assumes ccs_regs.svh supplies the counts
`include "ccs_regs.svh"

package ccs_pkg;

  typedef logic [7:0]              ccs_addr_t;
  typedef logic [7:0]              ccs_data_t;
  typedef logic [2:0]              ccs_stsel_t;
  typedef logic [`CCS_NSTAT-1:0]   ccs_stat_t;

  typedef enum logic [1:0] {
    CCS_H1_PERIPH  = 2'b00,
    CCS_H1_LOW     = 2'b01,
    CCS_H1_LOW_D8  = 2'b10,
    CCS_H1_LOW_D512 = 2'b11
  } ccs_h1_sel_t;

  typedef enum logic [1:0] {
    CCS_ST_IDLE  = 2'b00,
    CCS_ST_COUNT = 2'b01,
    CCS_ST_DONE  = 2'b10
  } ccs_state_t;

endpackage : ccs_pkg

// File: ccs_regs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes byte-wide register port with byte addresses
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CCS_ADDR_MCM      8'h00
`define CCS_ADDR_STSEL    8'h04
`define CCS_ADDR_STSTAT   8'h08
`define CCS_ADDR_PCTL     8'h0C
`define CCS_ADDR_OSC      8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define CCS_MCM_SYS_BIT   0
`define CCS_MCM_SRC_BIT   1
`define CCS_MCM_LOCK_BIT  7
`define CCS_PCTL_STOP_BIT 0
`define CCS_PCTL_INIT_BIT 1
`define CCS_PCTL_H1_LO    2
`define CCS_PCTL_H1_HI    3
`define CCS_PCTL_EXT_BIT  4
`define CCS_PCTL_TM0_BIT  5
`define CCS_PCTL_HOLD_BIT 6
`define CCS_OSC_EN_BIT    0
`define CCS_OSC_PRES_BIT  1
`define CCS_OSC_DONE_BIT  2

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define CCS_MCM_RST       8'h00
`define CCS_STSEL_RST     3'h4
`define CCS_STSEL_MAX     3'h4
`define CCS_NSTAT         5
`define CCS_STAB_EXP0     11
`define CCS_LS_DIV_W      9

`endif

// File: ccs_stab_counter.sv
// Oscillation stabilization counter with sticky status bits
// Assumes sel is held steady while a wait runs
`timescale 1ns/10ps

module ccs_stab_counter #(
  parameter int STAB_EXP0 = `CCS_STAB_EXP0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control side
  ccs_stab_if.cnt  sif
);
  import ccs_pkg::*;

  localparam int CNT_W = STAB_EXP0 + `CCS_NSTAT;

  ccs_state_t       state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r,   cnt_nxt;
  ccs_stat_t        stat_r,  stat_nxt;
  logic             done_r,  done_nxt;
  ccs_stsel_t       sel_c;

  function automatic logic [CNT_W-1:0] thr(input int idx);
    thr = {{(CNT_W-1){1'b0}}, 1'b1} << (STAB_EXP0 + idx);
  endfunction : thr

  // ****************************************************************
  // Counter
  // ****************************************************************
  always_comb begin
    sel_c     = (sif.sel > `CCS_STSEL_MAX) ? `CCS_STSEL_MAX : sif.sel;
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    stat_nxt  = stat_r;
    if (sif.restart) begin
      state_nxt = CCS_ST_COUNT;
      cnt_nxt   = '0;
      stat_nxt  = '0;
    end else begin
      unique case (state_r)
        CCS_ST_IDLE: begin
        end
        CCS_ST_COUNT: begin
          // No oscillation, no count: start-up time is excluded
          if (sif.osc_present) begin
            cnt_nxt = cnt_r + 1'b1;
            for (int i = 0; i < `CCS_NSTAT; i++) begin
              if (i <= int'(sel_c) && cnt_nxt == thr(i)) begin
                stat_nxt[i] = 1'b1;
              end
            end
            if (cnt_nxt == thr(int'(sel_c))) begin
              state_nxt = CCS_ST_DONE;
            end
          end
        end
        CCS_ST_DONE: begin
        end
        default: state_nxt = CCS_ST_IDLE;
      endcase
    end
    done_nxt = (state_nxt == CCS_ST_DONE);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= CCS_ST_IDLE;
      cnt_r   <= '0;
      stat_r  <= '0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      stat_r  <= stat_nxt;
      done_r  <= done_nxt;
    end
  end

  assign sif.status = stat_r;
  assign sif.done   = done_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  restart_clears_a: assert property (@(posedge clk) disable iff (reset)
    sif.restart |=> (stat_r == '0) && (cnt_r == '0)) else $error("restart did not clear");
  status_sticky_a: assert property (@(posedge clk) disable iff (reset)
    (stat_r != '0) && !sif.restart |=> (stat_r & $past(stat_r)) == $past(stat_r))
    else $error("status bit dropped");
  status_order_a: assert property (@(posedge clk) disable iff (reset)
    ((stat_r + 1'b1) & stat_r) == '0) else $error("status bits out of order");
  no_osc_hold_a: assert property (@(posedge clk) disable iff (reset)
    !sif.osc_present && !sif.restart |=> cnt_r == $past(cnt_r)) else $error("counted without oscillation");
  done_stops_a: assert property (@(posedge clk) disable iff (reset)
    done_r && !sif.restart |=> done_r && cnt_r == $past(cnt_r)) else $error("counter ran past chosen time");
  first_bit_a: assert property (@(posedge clk) disable iff (reset)
    state_r == CCS_ST_COUNT && sif.osc_present && !sif.restart && cnt_r == thr(0) - 1'b1
    |=> stat_r[0]) else $error("first status bit late");
  wait_done_c: cover property (@(posedge clk) disable iff (reset) sif.restart ##[1:1000] done_r);
endmodule : ccs_stab_counter

// File: ccs_stab_if.sv
// Link between the register front end and the stabilization counter
// Assumes both ends share clk
`timescale 1ns/10ps

interface ccs_stab_if;
  import ccs_pkg::*;
  logic       restart;
  logic       osc_present;
  ccs_stsel_t sel;
  ccs_stat_t  status;
  logic       done;

  modport ctrl (output restart, output osc_present, output sel, input status, input done);
  modport cnt  (input restart, input osc_present, input sel, output status, output done);
endinterface : ccs_stab_if

// File: ccs_top.sv
// Clock source select, clock routing and oscillation stabilization status
// Assumes a one-cycle register port and tick pulses synchronous to clk
//
// Functional notes
// - Stopped peripheral clock holds peripherals; reinit releases
// - Main source select changes once per reset
// - Watchdog always runs on low-speed clock
// - Timer H1 low-speed selections bypass peripheral clock
// - External-clocked peripherals bypass; timer zero input excepted
// - Status bits set in order, stay set
// - Counter stops at selected time, status limited
// - Wait counts only while oscillation present
`timescale 1ns/10ps

module ccs_top #(
  parameter int STAB_EXP0 = `CCS_STAB_EXP0
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Register port
  input  ccs_pkg::ccs_addr_t     reg_addr,
  input  ccs_pkg::ccs_data_t     reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output ccs_pkg::ccs_data_t     reg_rdata,
  // Oscillator and power state
  input  wire logic              osc_present,
  input  wire logic              stop_release,
  output logic                   osc_enable,
  output logic                   main_clock_source_select,
  output logic                   main_system_clock_select,
  output ccs_pkg::ccs_stat_t     stab_status,
  output logic                   stab_done,
  // Source ticks
  input  wire logic              low_tick,
  input  wire logic              periph_tick,
  input  wire logic              ext_tick,
  input  wire logic              tm0_edge,
  // Routed enables and peripheral hold
  output logic                   wdt_clk_en,
  output logic                   h1_clk_en,
  output logic                   peripheral_hw_clock,
  output logic                   ext_periph_clk_en,
  output logic                   tm0_clk_en,
  output logic                   periph_hold
);
  import ccs_pkg::*;

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic        sys_sel_r,  sys_sel_nxt;
  logic        src_sel_r,  src_sel_nxt;
  logic        src_lock_r, src_lock_nxt;
  ccs_stsel_t  stsel_r,    stsel_nxt;
  logic        pstop_r,    pstop_nxt;
  logic        hold_r,     hold_nxt;
  ccs_h1_sel_t h1_sel_r,   h1_sel_nxt;
  logic        ext_sel_r,  ext_sel_nxt;
  logic        tm0_sel_r,  tm0_sel_nxt;
  logic        osc_en_r,   osc_en_nxt;
  logic        restart_r,  restart_nxt;
  ccs_data_t   rdata_r,    rdata_nxt;
  logic        wr_mcm, wr_pctl, wr_osc, wr_stsel;

  ccs_stab_if sif ();

  function automatic logic hit(input ccs_addr_t a, input ccs_addr_t ofs);
    hit = (a == ofs);
  endfunction : hit

  always_comb begin
    wr_mcm   = reg_wr && hit(reg_addr, `CCS_ADDR_MCM);
    wr_stsel = reg_wr && hit(reg_addr, `CCS_ADDR_STSEL);
    wr_pctl  = reg_wr && hit(reg_addr, `CCS_ADDR_PCTL);
    wr_osc   = reg_wr && hit(reg_addr, `CCS_ADDR_OSC);

    sys_sel_nxt  = sys_sel_r;
    src_sel_nxt  = src_sel_r;
    src_lock_nxt = src_lock_r;
    stsel_nxt    = stsel_r;
    pstop_nxt    = pstop_r;
    hold_nxt     = hold_r;
    h1_sel_nxt   = h1_sel_r;
    ext_sel_nxt  = ext_sel_r;
    tm0_sel_nxt  = tm0_sel_r;
    osc_en_nxt   = osc_en_r;

    if (wr_mcm) begin
      sys_sel_nxt = reg_wdata[`CCS_MCM_SYS_BIT];
      // Only the first real change sticks; later writes are dropped silently
      if (!src_lock_r && reg_wdata[`CCS_MCM_SRC_BIT] != src_sel_r) begin
        src_sel_nxt  = reg_wdata[`CCS_MCM_SRC_BIT];
        src_lock_nxt = 1'b1;
      end
    end
    if (wr_stsel) begin
      stsel_nxt = reg_wdata[2:0];
    end
    if (wr_pctl) begin
      pstop_nxt   = reg_wdata[`CCS_PCTL_STOP_BIT];
      h1_sel_nxt  = ccs_h1_sel_t'(reg_wdata[`CCS_PCTL_H1_HI:`CCS_PCTL_H1_LO]);
      ext_sel_nxt = reg_wdata[`CCS_PCTL_EXT_BIT];
      tm0_sel_nxt = reg_wdata[`CCS_PCTL_TM0_BIT];
    end
    // Hold survives a restarted clock until software reinitializes
    if (pstop_nxt) begin
      hold_nxt = 1'b1;
    end else if (wr_pctl && reg_wdata[`CCS_PCTL_INIT_BIT]) begin
      hold_nxt = 1'b0;
    end
    if (wr_osc) begin
      osc_en_nxt = reg_wdata[`CCS_OSC_EN_BIT];
    end
    restart_nxt = (osc_en_nxt && !osc_en_r) || stop_release;

    rdata_nxt = 8'h00;
    if (reg_rd) begin
      if (hit(reg_addr, `CCS_ADDR_MCM)) begin
        rdata_nxt[`CCS_MCM_SYS_BIT]  = sys_sel_r;
        rdata_nxt[`CCS_MCM_SRC_BIT]  = src_sel_r;
        rdata_nxt[`CCS_MCM_LOCK_BIT] = src_lock_r;
      end else if (hit(reg_addr, `CCS_ADDR_STSEL)) begin
        rdata_nxt[2:0] = stsel_r;
      end else if (hit(reg_addr, `CCS_ADDR_STSTAT)) begin
        rdata_nxt[`CCS_NSTAT-1:0] = sif.status;
      end else if (hit(reg_addr, `CCS_ADDR_PCTL)) begin
        rdata_nxt[`CCS_PCTL_STOP_BIT]                  = pstop_r;
        rdata_nxt[`CCS_PCTL_H1_HI:`CCS_PCTL_H1_LO]     = h1_sel_r;
        rdata_nxt[`CCS_PCTL_EXT_BIT]                   = ext_sel_r;
        rdata_nxt[`CCS_PCTL_TM0_BIT]                   = tm0_sel_r;
        rdata_nxt[`CCS_PCTL_HOLD_BIT]                  = hold_r;
      end else if (hit(reg_addr, `CCS_ADDR_OSC)) begin
        rdata_nxt[`CCS_OSC_EN_BIT]   = osc_en_r;
        rdata_nxt[`CCS_OSC_PRES_BIT] = osc_present;
        rdata_nxt[`CCS_OSC_DONE_BIT] = sif.done;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sys_sel_r  <= 1'((`CCS_MCM_RST >> `CCS_MCM_SYS_BIT) & 8'h01);
      src_sel_r  <= 1'b0;
      src_lock_r <= 1'b0;
      stsel_r    <= `CCS_STSEL_RST;
      pstop_r    <= 1'b0;
      hold_r     <= 1'b0;
      h1_sel_r   <= CCS_H1_PERIPH;
      ext_sel_r  <= 1'b0;
      tm0_sel_r  <= 1'b0;
      osc_en_r   <= 1'b0;
      restart_r  <= 1'b0;
      rdata_r    <= 8'h00;
    end else begin
      sys_sel_r  <= sys_sel_nxt;
      src_sel_r  <= src_sel_nxt;
      src_lock_r <= src_lock_nxt;
      stsel_r    <= stsel_nxt;
      pstop_r    <= pstop_nxt;
      hold_r     <= hold_nxt;
      h1_sel_r   <= h1_sel_nxt;
      ext_sel_r  <= ext_sel_nxt;
      tm0_sel_r  <= tm0_sel_nxt;
      osc_en_r   <= osc_en_nxt;
      restart_r  <= restart_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Stabilization counter and clock routing
  // ****************************************************************
  // Software must keep the time select steady during a wait
  assign sif.restart     = restart_r;
  assign sif.osc_present = osc_present;
  assign sif.sel         = stsel_r;

  ccs_stab_counter #(
    .STAB_EXP0 (STAB_EXP0)
  ) u_stab (
    .clk   (clk),
    .reset (reset),
    .sif   (sif.cnt)
  );

  ccs_clk_route u_route (
    .clk         (clk),
    .reset       (reset),
    .low_tick    (low_tick),
    .periph_tick (periph_tick),
    .ext_tick    (ext_tick),
    .tm0_edge    (tm0_edge),
    .periph_stop (pstop_r),
    .h1_sel      (h1_sel_r),
    .ext_sel     (ext_sel_r),
    .tm0_ext_sel (tm0_sel_r),
    .wdt_en_r    (wdt_clk_en),
    .h1_en_r     (h1_clk_en),
    .periph_en_r (peripheral_hw_clock),
    .ext_en_r    (ext_periph_clk_en),
    .tm0_en_r    (tm0_clk_en)
  );

  assign reg_rdata                = rdata_r;
  assign osc_enable               = osc_en_r;
  assign main_clock_source_select = src_sel_r;
  assign main_system_clock_select = sys_sel_r;
  assign stab_status              = sif.status;
  assign stab_done                = sif.done;
  assign periph_hold              = hold_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  src_locked_a: assert property (@(posedge clk) disable iff (reset)
    src_lock_r |=> src_sel_r == $past(src_sel_r)) else $error("source select changed twice");
  src_first_a: assert property (@(posedge clk) disable iff (reset)
    !src_lock_r && wr_mcm && reg_wdata[`CCS_MCM_SRC_BIT] != src_sel_r
    |=> src_lock_r && src_sel_r == $past(reg_wdata[`CCS_MCM_SRC_BIT])) else $error("first change lost");
  hold_stop_a: assert property (@(posedge clk) disable iff (reset)
    pstop_r |-> hold_r) else $error("peripheral not held while clock stopped");
  hold_release_a: assert property (@(posedge clk) disable iff (reset)
    hold_r && !pstop_r && !(wr_pctl && reg_wdata[`CCS_PCTL_INIT_BIT]) |=> hold_r)
    else $error("hold released without reinit");
  release_restart_a: assert property (@(posedge clk) disable iff (reset)
    stop_release |=> restart_r ##1 stab_status == '0) else $error("STOP release did not restart");
  // Only newly set bits are limited; old bits stay until the next restart
  status_limit_a: assert property (@(posedge clk) disable iff (reset)
    ((stab_status & ~$past(stab_status)) >> ({1'b0, stsel_r} + 4'h1)) == '0)
    else $error("status beyond selected time");
  read_lat_a: assert property (@(posedge clk) disable iff (reset)
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data outside read cycle");
  lock_c:    cover property (@(posedge clk) disable iff (reset) src_lock_r && wr_mcm);
  reinit_c:  cover property (@(posedge clk) disable iff (reset) $fell(hold_r));
  release_c: cover property (@(posedge clk) disable iff (reset) stop_release ##[1:100] stab_status[0]);
endmodule : ccs_top

// File: tb.sv
// Self-checking bench for the clock source and stabilization block
// Assumes ccs_pkg and ccs_regs.svh are compiled first; bench drives every port
`timescale 1ns/10ps
`include "ccs_regs.svh"

module tb;
  import ccs_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int EXP0 = 2;
  logic      clk = 1'b0;
  logic      reset = 1'b1;
  ccs_addr_t reg_addr = 8'h00;
  ccs_data_t reg_wdata = 8'h00;
  logic      reg_wr = 1'b0;
  logic      reg_rd = 1'b0;
  ccs_data_t reg_rdata;
  logic      osc_present = 1'b0;
  logic      stop_release = 1'b0;
  logic      osc_enable, main_clock_source_select, main_system_clock_select, stab_done;
  ccs_stat_t stab_status;
  logic      low_tick = 1'b0;
  logic      periph_tick = 1'b0;
  logic      ext_tick = 1'b0;
  logic      tm0_edge = 1'b0;
  logic      wdt_clk_en, h1_clk_en, peripheral_hw_clock, ext_periph_clk_en, tm0_clk_en, periph_hold;
  int        num_errors = 0;
  int        check_count = 0;
  int        cycles = 0;
  ccs_data_t rd_v;
  logic [4:0] en_v;
  int        hits;

  always #12.5 clk = ~clk;

  ccs_top #(.STAB_EXP0(EXP0)) i_ccs_top (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_present(osc_present), .stop_release(stop_release),
    .osc_enable(osc_enable), .main_clock_source_select(main_clock_source_select),
    .main_system_clock_select(main_system_clock_select), .stab_status(stab_status), .stab_done(stab_done),
    .low_tick(low_tick), .periph_tick(periph_tick), .ext_tick(ext_tick), .tm0_edge(tm0_edge),
    .wdt_clk_en(wdt_clk_en), .h1_clk_en(h1_clk_en), .peripheral_hw_clock(peripheral_hw_clock),
    .ext_periph_clk_en(ext_periph_clk_en), .tm0_clk_en(tm0_clk_en), .periph_hold(periph_hold)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input ccs_addr_t a, input ccs_data_t d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input ccs_addr_t a, output ccs_data_t d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // Ticks as {low, periph, ext, tm0}; enables as {wdt, h1, periph, ext, tm0}
  task automatic tick(input logic [3:0] t, output logic [4:0] e);
    @(posedge clk);
    {low_tick, periph_tick, ext_tick, tm0_edge} <= t;
    @(posedge clk);
    {low_tick, periph_tick, ext_tick, tm0_edge} <= 4'h0;
    #1;
    e = {wdt_clk_en, h1_clk_en, peripheral_hw_clock, ext_periph_clk_en, tm0_clk_en};
  endtask : tick

  task automatic route(input ccs_data_t pctl, input logic [3:0] t, input logic [4:0] exp);
    wr(`CCS_ADDR_PCTL, pctl);
    tick(t, en_v);
    chk("enables", {3'h0, exp}, {3'h0, en_v});
  endtask : route

  // Restart by stop release, then time the wait to done
  task automatic stab_run(input logic [2:0] s);
    int n;
    int e;
    e = 1 << (EXP0 + s);
    wr(`CCS_ADDR_STSEL, {5'h00, s});
    @(posedge clk);
    stop_release <= 1'b1;
    @(posedge clk);
    stop_release <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("status_cleared", 8'h00, {3'h0, stab_status});
    n = 2;
    while (stab_done !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("done_in_window", 8'h01, {7'h00, (n >= e && n <= e + 5)});
    repeat (80) @(posedge clk);
    #1;
    chk("status_limit", 8'((1 << (s + 1)) - 1), {3'h0, stab_status});
  endtask : stab_run

  // ****************************************************************
  // Monitors
  // ****************************************************************
  // Status may only fill from bit0 upward, never with a gap
  always @(posedge clk) begin
    if (reset === 1'b0 && (stab_status & (stab_status + 5'h01)) !== 5'h00) begin
      num_errors++;
      $display("BAD stab_order expected contiguous seen %h", stab_status);
    end
  end

  // Longest path is the /512 divider pass, about 2100 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(`CCS_ADDR_MCM, rd_v);    chk("mcm_reset", 8'h00, rd_v);
    rd(`CCS_ADDR_STSEL, rd_v);  chk("stsel_reset", 8'h04, rd_v);
    rd(`CCS_ADDR_STSTAT, rd_v); chk("stat_reset", 8'h00, rd_v);
    wr(8'h20, 8'hFF);
    rd(8'h20, rd_v);            chk("unmapped", 8'h00, rd_v);
    wr(`CCS_ADDR_STSTAT, 8'hFF);
    rd(`CCS_ADDR_STSTAT, rd_v); chk("stat_ro", 8'h00, rd_v);
    $display("test registers done");

    wr(`CCS_ADDR_MCM, 8'h02);
    rd(`CCS_ADDR_MCM, rd_v);    chk("mcm_first", 8'h82, rd_v);
    wr(`CCS_ADDR_MCM, 8'h01);
    rd(`CCS_ADDR_MCM, rd_v);    chk("mcm_locked", 8'h83, rd_v);
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    wr(`CCS_ADDR_MCM, 8'h02);
    #1;
    chk("src_after_reset", 8'h01, {7'h00, main_clock_source_select});
    wr(`CCS_ADDR_MCM, 8'h03);   // main select changes stay off the routing
    #1;
    chk("sys_sel", 8'h01, {7'h00, main_system_clock_select});
    chk("src_kept", 8'h01, {7'h00, main_clock_source_select});
    $display("test source lock done");

    route(8'h00, 4'b1000, 5'b10000);
    route(8'h00, 4'b0100, 5'b01111);
    route(8'h04, 4'b1000, 5'b11000);
    route(8'h04, 4'b0100, 5'b00111);
    route(8'h10, 4'b0010, 5'b00010);
    route(8'h10, 4'b0100, 5'b01101);
    route(8'h20, 4'b0001, 5'b00000);
    route(8'h20, 4'b0101, 5'b01111);
    route(8'h21, 4'b1101, 5'b10000);
    route(8'h05, 4'b1100, 5'b11000);
    chk("hold_set", 8'h01, {7'h00, periph_hold});
    wr(`CCS_ADDR_PCTL, 8'h00);
    #1;
    chk("hold_kept", 8'h01, {7'h00, periph_hold});
    wr(`CCS_ADDR_PCTL, 8'h02);
    #1;
    chk("hold_release", 8'h00, {7'h00, periph_hold});
    for (int s = 2; s <= 3; s++) begin
      wr(`CCS_ADDR_PCTL, 8'(s << 2));
      hits = 0;
      for (int k = 0; k < ((s == 2) ? 16 : 1024); k++) begin
        tick(4'b1000, en_v);
        hits += en_v[3];
      end
      chk("h1_divided", 8'h02, 8'(hits));
    end
    $display("test routing done");

    wr(`CCS_ADDR_STSEL, 8'h02);
    wr(`CCS_ADDR_OSC, 8'h01);
    #1;
    chk("osc_enable", 8'h01, {7'h00, osc_enable});
    repeat (60) @(posedge clk);
    #1;
    chk("no_osc_status", 8'h00, {2'h0, stab_done, stab_status});
    rd(`CCS_ADDR_OSC, rd_v);    chk("osc_reg_idle", 8'h01, rd_v);
    @(posedge clk);
    osc_present <= 1'b1;
    hits = 0;
    while (stab_done !== 1'b1 && hits < 300) begin
      @(posedge clk);
      #1;
      hits++;
    end
    chk("osc_wait", 8'h01, {7'h00, (hits >= 16 && hits <= 19)});
    rd(`CCS_ADDR_STSTAT, rd_v); chk("stat_read", 8'h07, rd_v);
    rd(`CCS_ADDR_OSC, rd_v);    chk("osc_reg_done", 8'h07, rd_v);
    for (int s = 0; s <= 4; s++) stab_run(3'(s));
    $display("test stabilization done");
    conclude();
  end
endmodule : tb
